// >>> hw/dmt_timer_regs.svh
// Purpose: offsets, field positions, reset values and counts of the 8-bit compare timer
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   included by bare name
// Summary of operation
// - interval match raises irq, clears counter
// - interval mode ignores duty compare completely
// - output enable gives 50 percent square wave
// - interval period is N plus one ticks
// - counting starts within one count tick
// - interval match clears, toggles output, pulses irq
// - interval stop returns irq, output to idle
// - PWM cycle match: clear, irq, active, duty
// - PWM duty match: inactive, back to cycle
// - PWM period N+1, active width M+1
// - duty write applies at match after three ticks
// - PWM start masks first tick, output inactive
// - PWM stop returns irq idle, output inactive
// - carrier only on second instance, low/high widths
// - carrier output follows select and envelope bits
// - buffer bit writable, active bit read-only
// - active bit loads at second tick after pulse
// - run off holds counter at zero
// - idle level bit picks output default level
`ifndef DMT_TIMER_REGS_SVH
`define DMT_TIMER_REGS_SVH
`define DMT_OFF_MODE   5'h00
`define DMT_OFF_CYCLE  5'h04
`define DMT_OFF_DUTY   5'h08
`define DMT_OFF_CARR   5'h0C
`define DMT_OFF_STAT   5'h10
`define DMT_MD_INTERVAL 2'h0
`define DMT_MD_CARRIER  2'h1
`define DMT_MD_PWM      2'h2
`define DMT_CARR_RMC   2
`define DMT_CARR_NRZB  1
`define DMT_CARR_NRZ   0
`define DMT_STAT_PHASE 8
`define DMT_RST_BYTE   8'h00
`define DMT_CNT_CLEAR  8'h00
`define DMT_DUTY_SETTLE 2'h3
`define DMT_XFER_TICKS  2'h2
`define DMT_RDATA_ZERO 32'h0000_0000
`endif

// >>> hw/dmt_pkg.sv
// Purpose: types shared by the compare timer
// Assumes: nothing
// Notes:   mode register fields travel as one packed struct
`default_nettype none
package dmt_pkg;
  // mode control register, msb first as it sits in the word
  typedef struct packed {
    logic       run;   // count_run_enable
    logic [2:0] cks;   // count_clock_select
    logic [1:0] md;    // operating mode
    logic       lev;   // idle_output_level
    logic       toen;  // timer_output_enable
  } dmt_mode_s;
  // which compare register is armed
  typedef enum logic {PH_CYCLE, PH_DUTY} dmt_phase_e;
  typedef logic [7:0] dmt_byte_t;
endpackage
`default_nettype wire

// >>> hw/dmt_timer.sv
// Purpose: 8-bit up-counter with cycle and duty compare: interval, PWM and carrier modes
// Assumes: 40 MHz clk; count clock is clk divided by 2**count_clock_select
// Notes:   Avalon-MM slave, answers one cycle after a request is seen
`include "dmt_timer_regs.svh"
`default_nettype none
module dmt_timer
  import dmt_pkg::*;
#(
  parameter bit HAS_CARRIER = 1'b1  // set on the second instance only
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        envelope_timer_event,
  output var  logic        timer_output,
  output var  logic        match_irq
);

  // reset release and pin synchroniser flops
  logic [1:0]  rst_s_r;       // reset release pair
  logic        rst_n;         // released reset copy
  logic [1:0]  ev_s_r;        // envelope event pin sync
  logic        ev_lvl;        // synchronised envelope level
  // software visible state, except the duty transfer flops
  dmt_mode_s   mode_r;        // mode_control_reg
  dmt_byte_t   cyc_r;         // cycle_compare / carrier_low_compare
  dmt_byte_t   duty_wr_r;     // duty_compare as written
  dmt_byte_t   duty_act_r;    // duty value the comparator uses
  logic        duty_pend_r;   // written value waiting for transfer
  logic [1:0]  duty_age_r;    // ticks since that write, saturating
  logic        rmc_r;         // remote_carrier_select
  logic        nrzb_r;        // envelope_buffer_bit
  logic        nrz_r;         // envelope_active_bit
  // counting core
  dmt_byte_t   pre_r;         // free-running prescaler
  dmt_byte_t   div_mask;      // prescaler bits that must be all ones
  logic        tick;          // one count clock edge
  dmt_byte_t   cnt_r;         // the 8-bit counter
  dmt_phase_e  phase_r;       // armed compare register
  logic        mask_r;        // swallow the first tick after a PWM start
  logic        mask_on;       // mask really applies, PWM only
  dmt_byte_t   cmp_val;       // value under comparison
  logic        hit;           // compare match on this tick
  logic        cyc_hit;       // match against the cycle register
  logic        duty_hit;      // match against the duty register
  logic        car_md;        // carrier mode really available
  logic        pwm_md;        // PWM mode
  logic        int_md;        // interval mode (also prohibited codes)
  logic        car_r;         // raw carrier square wave
  logic        out_r;         // timer_output flop
  logic        irq_r;         // match_irq flop
  logic        ev_q_r;        // envelope level seen at the last tick
  logic        env_pulse;     // envelope_sync_pulse
  logic [1:0]  xfer_r;        // ticks left before buffer-to-active copy
  // bus slave
  logic        wait_r;        // waitrequest flop
  logic [31:0] rdata_r;       // readdata flop
  logic        wr_go;         // write takes effect this edge
  logic        rd_go;         // read data captured this edge

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s_r <= 2'h0;
    end else begin
      rst_s_r <= {rst_s_r[0], 1'b1};
    end
  end
  assign rst_n = rst_s_r[1];

  // envelope event comes from another timer block, treat it as a pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s_r <= 2'h0;
    end else begin
      ev_s_r <= {ev_s_r[0], envelope_timer_event};
    end
  end
  assign ev_lvl = ev_s_r[1];

  default clocking dmt_cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // mode decode; carrier code falls back to interval on the first instance
  assign car_md = HAS_CARRIER && (mode_r.md == `DMT_MD_CARRIER);
  assign pwm_md = (mode_r.md == `DMT_MD_PWM);
  assign int_md = !car_md && !pwm_md;

  // bus handshake: one wait cycle, then a single acknowledged cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else if ((avs_read || avs_write) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end
  assign wr_go = avs_write && !wait_r && avs_byteenable[0];
  assign rd_go = avs_read && wait_r;

  // read mux, loaded on the same edge that waitrequest drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `DMT_RDATA_ZERO;
    end else if (rd_go) begin
      case (avs_address)
        `DMT_OFF_MODE:  rdata_r <= {24'h000000, mode_r};
        `DMT_OFF_CYCLE: rdata_r <= {24'h000000, cyc_r};
        `DMT_OFF_DUTY:  rdata_r <= {24'h000000, duty_wr_r};
        // active bit is visible but never written
        `DMT_OFF_CARR:  rdata_r <= HAS_CARRIER ? {29'h00000000, rmc_r, nrzb_r, nrz_r} : `DMT_RDATA_ZERO;
        `DMT_OFF_STAT:  rdata_r <= {23'h000000, phase_r == PH_DUTY, cnt_r};
        default:        rdata_r <= `DMT_RDATA_ZERO; // unmapped reads zero
      endcase
    end
  end

  // mode and cycle registers; writes while running are accepted as is
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= dmt_mode_s'(`DMT_RST_BYTE);
      cyc_r  <= `DMT_RST_BYTE;
    end else if (wr_go && avs_address == `DMT_OFF_MODE) begin
      mode_r <= dmt_mode_s'(avs_writedata[7:0]);
    end else if (wr_go && avs_address == `DMT_OFF_CYCLE) begin
      cyc_r <= avs_writedata[7:0];
    end
  end

  // carrier control; only the buffer and select bits are writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rmc_r  <= 1'b0;
      nrzb_r <= 1'b0;
    end else if (HAS_CARRIER && wr_go && avs_address == `DMT_OFF_CARR) begin
      rmc_r  <= avs_writedata[`DMT_CARR_RMC];
      nrzb_r <= avs_writedata[`DMT_CARR_NRZB];
    end
  end

  // count clock: a tick whenever the low prescaler bits are all ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= `DMT_RST_BYTE;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end
  assign div_mask = 8'((9'h001 << mode_r.cks) - 9'h001);
  assign tick     = (pre_r & div_mask) == div_mask;

  // comparator; interval mode never arms the duty register
  assign cmp_val  = (phase_r == PH_DUTY) ? duty_act_r : cyc_r;
  assign mask_on  = mask_r && pwm_md;
  assign hit      = mode_r.run && tick && !mask_on && (cnt_r == cmp_val);
  assign cyc_hit  = hit && (phase_r == PH_CYCLE);
  assign duty_hit = hit && (phase_r == PH_DUTY);

  // first-tick mask, armed whenever stopped: a mode word that selects PWM
  // and sets run in one write must still lose its first tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 1'b0;
    end else if (!mode_r.run) begin
      mask_r <= 1'b1;
    end else if (tick) begin
      mask_r <= 1'b0;
    end
  end

  // counter: held at zero while stopped, cleared on a clearing match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= `DMT_CNT_CLEAR;
    end else if (!mode_r.run) begin
      cnt_r <= `DMT_CNT_CLEAR;
    end else if (tick && !mask_on) begin
      if (cyc_hit || (duty_hit && car_md)) begin
        cnt_r <= `DMT_CNT_CLEAR;
      end else begin
        cnt_r <= cnt_r + 8'h01; // duty hit in PWM keeps counting
      end
    end
  end

  // phase swaps on every match except in interval mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_CYCLE;
    end else if (!mode_r.run || int_md) begin
      phase_r <= PH_CYCLE;
    end else if (cyc_hit) begin
      phase_r <= PH_DUTY;
    end else if (duty_hit) begin
      phase_r <= PH_CYCLE;
    end
  end

  // match interrupt: one clk pulse on a tick; none on a PWM duty match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= cyc_hit || (duty_hit && car_md);
    end
  end

  // duty buffer: a write while running waits for a duty match, and only
  // transfers once three ticks have passed since the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_wr_r   <= `DMT_RST_BYTE;
      duty_act_r  <= `DMT_RST_BYTE;
      duty_pend_r <= 1'b0;
      duty_age_r  <= 2'h0;
    end else if (wr_go && avs_address == `DMT_OFF_DUTY) begin
      duty_wr_r <= avs_writedata[7:0];
      if (!mode_r.run) begin
        duty_act_r  <= avs_writedata[7:0]; // stopped: takes effect at once
        duty_pend_r <= 1'b0;
      end else begin
        duty_pend_r <= 1'b1;
        duty_age_r  <= 2'h0;
      end
    end else if (duty_hit && duty_pend_r && duty_age_r == `DMT_DUTY_SETTLE) begin
      duty_act_r  <= duty_wr_r;
      duty_pend_r <= 1'b0;
    end else if (tick && duty_pend_r && duty_age_r != `DMT_DUTY_SETTLE) begin
      duty_age_r <= duty_age_r + 2'h1;
    end
  end

  // raw carrier: low for low-width compare, high for high-width compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      car_r <= 1'b0;
    end else if (!mode_r.run || !car_md) begin
      car_r <= 1'b0;
    end else if (hit) begin
      car_r <= !car_r;
    end
  end

  // envelope event resampled on count ticks gives the sync pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_q_r <= 1'b0;
    end else if (tick) begin
      ev_q_r <= ev_lvl;
    end
  end
  assign env_pulse = car_md && tick && ev_lvl && !ev_q_r;

  // buffer-to-active copy lands on the second tick after the pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_r <= 2'h0;
      nrz_r  <= 1'b0;
    end else if (!car_md) begin
      xfer_r <= 2'h0;
    end else if (env_pulse) begin
      xfer_r <= `DMT_XFER_TICKS;
    end else if (tick && xfer_r != 2'h0) begin
      xfer_r <= xfer_r - 2'h1;
      if (xfer_r == 2'h1) begin
        nrz_r <= nrzb_r;
      end
    end
  end

  // output pin: idle level when disabled, or when stopped outside carrier mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else if (!mode_r.toen) begin
      out_r <= mode_r.lev;
    end else if (car_md) begin
      // envelope gates the carrier; select 0 sends a plain high
      out_r <= nrz_r && (!rmc_r || car_r);
    end else if (!mode_r.run) begin
      out_r <= mode_r.lev;
    end else if (pwm_md && cyc_hit) begin
      out_r <= !mode_r.lev;
    end else if (pwm_md && duty_hit) begin
      out_r <= mode_r.lev;
    end else if (int_md && hit) begin
      out_r <= !out_r;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign timer_output    = out_r;
  assign match_irq       = irq_r;

  // checks
  sequence s_int_hit;
    mode_r.run && int_md && tick && !mask_on && cnt_r == cyc_r;
  endsequence
  sequence s_pwm_cyc;
    pwm_md && cyc_hit;
  endsequence
  sequence s_pwm_duty;
    pwm_md && duty_hit;
  endsequence

  stop_holds_a: assert property (!mode_r.run |=> cnt_r == `DMT_CNT_CLEAR && !irq_r)
    else $error("stopped timer counts or interrupts");
  int_clear_a: assert property (s_int_hit |=> cnt_r == `DMT_CNT_CLEAR && irq_r)
    else $error("interval match did not clear and interrupt");
  duty_unused_a: assert property (int_md |=> phase_r == PH_CYCLE)
    else $error("interval mode armed duty compare");
  square_flip_a: assert property (s_int_hit ##0 mode_r.toen |=> out_r != $past(out_r))
    else $error("interval match did not toggle output");
  pwm_cycle_a: assert property (s_pwm_cyc ##0 mode_r.toen |=> irq_r && out_r != mode_r.lev && phase_r == PH_DUTY)
    else $error("pwm cycle match wrong");
  pwm_duty_a: assert property (s_pwm_duty ##0 mode_r.toen |=> !irq_r && out_r == mode_r.lev && cnt_r != `DMT_CNT_CLEAR)
    else $error("pwm duty match wrong");
  pwm_mask_a: assert property ($rose(mode_r.run) && pwm_md |-> mask_r ##1 cnt_r == `DMT_CNT_CLEAR)
    else $error("pwm start tick not masked");
  stop_level_a: assert property ($fell(mode_r.run) && mode_r.toen && !car_md |=> out_r == mode_r.lev)
    else $error("stop did not restore idle level");
  duty_early_a: assert property (duty_hit && (wr_go && avs_address == `DMT_OFF_DUTY
                                 || duty_pend_r && duty_age_r != `DMT_DUTY_SETTLE)
                                |=> duty_act_r == $past(duty_act_r))
    else $error("early duty write transferred");
  env_copy_a: assert property (env_pulse && div_mask == 8'h00 ##1 car_md [*2] |-> ##1 nrz_r == $past(nrzb_r))
    else $error("envelope transfer not armed");
  env_gate_a: assert property (car_md && mode_r.toen && !nrz_r |=> !out_r)
    else $error("carrier output not gated low");

endmodule
`default_nettype wire

// >>> verif/dmt_env_model.sv
// Purpose: stand-in for the envelope timer that drives the event line
// Assumes: one fire pulse from the bench per envelope edge
// Notes:   line idles low outside events
`default_nettype none
module dmt_env_model #(
  parameter int HOLD = 4  // event high time in clk cycles
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic fire,
  output var  logic envelope_timer_event
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_r;  // high cycles still to go
  // held for several clocks so the two-flop sync cannot miss it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 0;
    end else if (fire) begin
      cnt_r <= HOLD;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end
  end
  assign envelope_timer_event = (cnt_r > 0);
endmodule
`default_nettype wire

// >>> verif/dmt_timer_test.sv
// Purpose: self-checking bench for the compare timer, both instances
// Assumes: one wait cycle per bus access, count select 0 is every clk
// Notes:   widths are counted in clk edges between output changes
`include "dmt_timer_regs.svh"
`default_nettype none
module dmt_timer_test
  import dmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, nrst, avs_read, avs_write, fire;    // bench drives
  logic [4:0]  avs_address;                             // byte address
  logic [31:0] avs_writedata, avs_readdata, rd_h0;      // bus data
  logic [31:0] rdata, rdata_h0;                         // captured reads
  logic        avs_waitrequest, wr_h0, to_h0, irq_h0;   // slave answers
  logic        timer_output, match_irq, envelope_timer_event;
  int          miscompares, n_tests, n, h, l;            // bookkeeping
  logic        ok;                                      // level held flag
  // second instance, carrier capable
  dmt_timer #(.HAS_CARRIER(1'b1)) u_dmt_timer (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .envelope_timer_event(envelope_timer_event), .timer_output(timer_output), .match_irq(match_irq));
  // first instance shares the bus; carrier register must stay empty
  dmt_timer #(.HAS_CARRIER(1'b0)) u_dmt_timer_h0 (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(rd_h0), .avs_waitrequest(wr_h0),
    .envelope_timer_event(envelope_timer_event), .timer_output(to_h0), .match_irq(irq_h0));
  dmt_env_model u_dmt_env_model (.clk(clk), .nrst(nrst), .fire(fire),
    .envelope_timer_event(envelope_timer_event));
  // 40 MHz
  always #12.5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict, the one place the run ends
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdata = avs_readdata;
    rdata_h0 = rd_h0;
    chk(wr_h0, 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 50) begin
      miscompares++;
      close_out();
    end
  endtask
  // edges until the chosen pin reaches v: 0 output, 1 irq, 2 and 3 first instance irq and output
  task automatic wt(input logic [1:0] sel, input logic v, output int k);
    logic s;  // chosen pin as sampled
    k = 0;
    do begin
      @(posedge clk);
      k++;
      s = sel[1] ? (sel[0] ? to_h0 : irq_h0) : (sel[0] ? match_irq : timer_output);
    end while ((s !== v) && k < 600);
    if (k >= 600) begin
      miscompares++;
      close_out();
    end
  endtask
  // mode word from its fields
  function automatic logic [31:0] md(logic run, logic [2:0] cks, logic [1:0] m, logic lev, logic toen);
    dmt_mode_s s;
    s = '{run: run, cks: cks, md: m, lev: lev, toen: toen};
    return {24'h000000, s};
  endfunction
  // output must hold v for c edges
  task automatic hold(input logic v, input int c);
    ok = 1'b1;
    repeat (c) begin
      @(posedge clk);
      if (timer_output !== v) ok = 1'b0;
    end
  endtask
  // one envelope event, then time for sync and transfer
  task automatic env();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    fire = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, hole at 14 reads zero
    for (int a = 0; a <= 20; a += 4) begin
      bus(1'b0, 5'(a), 32'h0);
      chk(rdata, 32'h0);
    end
    // interval, N = 3
    bus(1'b1, `DMT_OFF_CYCLE, 32'h03);
    bus(1'b1, `DMT_OFF_MODE, md(1, 3'h0, `DMT_MD_INTERVAL, 0, 1));
    wt(1, 1, n);
    chk(n >= 3 && n <= 6, 1);
    bus(1'b1, `DMT_OFF_DUTY, 32'h01);  // must not disturb anything
    wt(1, 1, n);
    wt(1, 1, n);
    chk(n, 4);
    wt(0, 0, n);
    wt(0, 1, n);
    wt(0, 0, h);
    chk(h, 4);
    wt(0, 1, n);
    bus(1'b1, `DMT_OFF_MODE, md(0, 3'h0, `DMT_MD_INTERVAL, 0, 1));
    repeat (2) @(posedge clk);
    chk(timer_output, 0);
    chk(match_irq, 0);
    bus(1'b0, `DMT_OFF_STAT, 32'h0);
    chk(rdata, 32'h0);
    // count clock at clk/2 doubles the period
    bus(1'b1, `DMT_OFF_MODE, md(1, 3'h1, `DMT_MD_INTERVAL, 0, 1));
    wt(1, 1, n);
    wt(1, 1, n);
    chk(n, 8);
    bus(1'b1, `DMT_OFF_MODE, md(0, 3'h0, `DMT_MD_INTERVAL, 1, 1));
    repeat (2) @(posedge clk);
    chk(timer_output, 1);
    bus(1'b1, `DMT_OFF_MODE, md(0, 3'h0, `DMT_MD_INTERVAL, 0, 1));
    // PWM, N = 7, M = 3, stopped writes only
    bus(1'b1, `DMT_OFF_CYCLE, 32'h07);
    bus(1'b1, `DMT_OFF_DUTY, 32'h03);
    bus(1'b1, `DMT_OFF_MODE, md(1, 3'h0, `DMT_MD_PWM, 0, 1));
    hold(0, 9);
    chk(ok, 1);
    wt(0, 1, n);
    chk(match_irq, 1);
    wt(0, 0, h);
    chk(h, 4);
    chk(match_irq, 0);
    wt(0, 1, l);
    chk(h + l, 8);
    // write lands on the duty match itself: old width holds one more period
    bus(1'b1, `DMT_OFF_DUTY, 32'h01);
    wt(0, 0, h);
    chk(h, 1);
    wt(0, 1, n);
    wt(0, 0, h);
    chk(h, 4);
    wt(0, 1, n);
    wt(0, 0, h);
    chk(h, 2);
    bus(1'b1, `DMT_OFF_DUTY, 32'h03);  // far from the match, transfers
    wt(0, 1, n);
    bus(1'b1, `DMT_OFF_MODE, md(0, 3'h0, `DMT_MD_PWM, 0, 1));
    repeat (2) @(posedge clk);
    chk(timer_output, 0);
    chk(match_irq, 0);
    // carrier, low 3 and high 2
    bus(1'b1, `DMT_OFF_CYCLE, 32'h02);
    bus(1'b1, `DMT_OFF_DUTY, 32'h01);
    bus(1'b1, `DMT_OFF_CARR, 32'h07);
    bus(1'b0, `DMT_OFF_CARR, 32'h0);
    chk(rdata, 32'h06);
    chk(rdata_h0, 32'h0);
    bus(1'b1, `DMT_OFF_MODE, md(1, 3'h0, `DMT_MD_CARRIER, 0, 1));
    hold(0, 10);
    chk(ok, 1);
    env();
    bus(1'b0, `DMT_OFF_CARR, 32'h0);
    chk(rdata, 32'h07);
    wt(0, 0, n);
    wt(0, 1, n);
    wt(0, 0, h);
    chk(h, 2);
    wt(0, 1, l);
    chk(l, 3);
    // first instance runs the carrier code as an interval timer
    wt(2'h2, 1, n);
    wt(2'h2, 1, h);
    chk(h, 3);
    wt(2'h3, 0, n);
    wt(2'h3, 1, n);
    wt(2'h3, 0, h);
    chk(h, 3);
    bus(1'b1, `DMT_OFF_CARR, 32'h04);
    env();
    bus(1'b0, `DMT_OFF_CARR, 32'h0);
    chk(rdata, 32'h04);
    hold(0, 10);
    chk(ok, 1);
    // select off: steady high, select only changed while stopped
    bus(1'b1, `DMT_OFF_MODE, md(0, 3'h0, `DMT_MD_CARRIER, 0, 1));
    bus(1'b1, `DMT_OFF_CARR, 32'h02);
    bus(1'b1, `DMT_OFF_DUTY, 32'h01);
    bus(1'b1, `DMT_OFF_MODE, md(1, 3'h0, `DMT_MD_CARRIER, 0, 1));
    env();
    hold(1, 10);
    chk(ok, 1);
    bus(1'b0, `DMT_OFF_CARR, 32'h0);
    chk(rdata, 32'h03);
    close_out();
  end
endmodule
`default_nettype wire
